/* shared/spi_erase_pkg.sv */
// constants, types and helpers shared by both ends of the erase link
package spi_erase_pkg;

   // command opcodes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hd7;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OP_FULL_ERASE = 8'hc7;

   // frame lengths in serial bits
   localparam logic [5:0] OP_BITS = 6'h08;
   localparam logic [5:0] ADDR_CMD_BITS = 6'h20;
   localparam logic [5:0] STATUS_BITS = 6'h10;

   // array geometry
   localparam int NUM_SECTORS = 8;
   localparam int SECTORS_PER_BLOCK = 8;
   localparam int SEC_IDX_W = 3;
   localparam int SEC_ADDR_LSB = 12;

   // status byte layout
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;

   // erase timing
   localparam int CLK_MHZ = 40;
   localparam int ERASE_TIME_US = 7000;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

   // host link pacing in clk_i cycles
   localparam int HOST_HALF_DIV = 4;
   localparam int HOST_GAP = 8;

   typedef enum logic [1:0] {
      KIND_SECTOR,
      KIND_BLOCK,
      KIND_FULL
   } erase_kind_t;

   typedef enum logic [2:0] {
      CMD_WRITE_ENABLE,
      CMD_READ_STATUS,
      CMD_SECTOR_ERASE,
      CMD_BLOCK_ERASE,
      CMD_FULL_ERASE
   } host_cmd_t;

   typedef enum logic {
      DEV_IDLE,
      DEV_ERASE
   } dev_state_t;

   typedef enum logic [1:0] {
      HOST_IDLE,
      HOST_SHIFT,
      HOST_HOLD,
      HOST_WAIT
   } host_state_t;

   // one bit per sector touched by an erase
   function automatic logic [NUM_SECTORS-1:0] region_mask(
      input erase_kind_t kind,
      input logic [SEC_IDX_W-1:0] sec);
      logic [NUM_SECTORS-1:0] m;
      m = '0;
      for (int i = 0; i < NUM_SECTORS; i++) begin
         case (kind)
            KIND_SECTOR: m[i] = (i == int'(sec));
            KIND_BLOCK: m[i] = ((i / SECTORS_PER_BLOCK) ==
                                (int'(sec) / SECTORS_PER_BLOCK));
            default: m[i] = 1'b1;
         endcase
      end
      return m;
   endfunction

endpackage

/* shared/spi_erase_if.sv */
// serial link between the erase host and the flash device
`timescale 1ns/10ps
`default_nettype none
interface spi_erase_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso_out;
   logic miso_oe;
   logic miso;

   // pulled high when the device does not drive
   assign miso = miso_oe ? miso_out : 1'b1;

   modport host (output sck, output cs_n, output mosi, input miso);
   modport dev (input sck, input cs_n, input mosi,
                output miso_out, output miso_oe);
endinterface
`default_nettype wire

/* hw/spi_erase_dev.sv */
// flash device end: command decode on the link clock, erase timer on clk_i
`timescale 1ns/10ps
`default_nettype none
module spi_erase_dev #(
   parameter int unsigned ERASE_CYCLES = spi_erase_pkg::ERASE_CYCLES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   spi_erase_if.dev spi,
   input wire logic [spi_erase_pkg::NUM_SECTORS-1:0] dirty_i,
   output logic erase_start_o,
   output logic erase_done_o,
   output logic busy_o,
   output logic [spi_erase_pkg::NUM_SECTORS-1:0] erase_mask_o,
   output logic [spi_erase_pkg::NUM_SECTORS-1:0] blank_o
);
   localparam int NS = spi_erase_pkg::NUM_SECTORS;
   localparam int SW = spi_erase_pkg::SEC_IDX_W;

   // ---------------- link clock domain ----------------
   logic frame_rst_n;
   logic [5:0] bitcnt_q, bitcnt_d;
   logic [31:0] shreg_q, shreg_d;
   logic rd_q, rd_d;
   logic write_enable_latch_q, write_enable_latch_d;
   logic seen_q, seen_d;
   logic valid_q, valid_d;
   spi_erase_pkg::erase_kind_t kind_q, kind_d;
   logic [SW-1:0] sidx_q, sidx_d;
   logic busy_s1_q, busy_s2_q;
   logic done_s1_q, done_s2_q;
   logic miso_q, miso_d;
   logic oe_q, oe_d;
   logic done_pend;
   logic latch_eff;
   logic [7:0] op8;
   logic [7:0] op32;
   logic [7:0] status;
   logic [2:0] sbit;

   // clk_i domain signals read by the link side
   logic busy_q, busy_d;
   logic done_tgl_q, done_tgl_d;

   // frame state is cleared whenever chip select is high
   assign frame_rst_n = arst_n_i & ~spi.cs_n;

   assign done_pend = done_s2_q != seen_q;
   assign latch_eff = write_enable_latch_q & ~done_pend;
   assign op8 = shreg_d[7:0];
   assign op32 = shreg_d[31:24];

   always_comb begin
      status = 8'h00;
      status[spi_erase_pkg::STAT_BUSY_BIT] = busy_s2_q;
      status[spi_erase_pkg::STAT_LATCH_BIT] = latch_eff;
   end

   // frame shifter
   always_comb begin
      bitcnt_d = (bitcnt_q == 6'h3f) ? bitcnt_q : bitcnt_q + 6'h01;
      shreg_d = {shreg_q[30:0], spi.mosi};
      rd_d = rd_q;
      if (bitcnt_d == spi_erase_pkg::OP_BITS &&
          op8 == spi_erase_pkg::OP_READ_STATUS) begin
         rd_d = 1'b1;
      end
   end

   always_ff @(posedge spi.sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bitcnt_q <= 6'h00;
         shreg_q <= 32'h0000_0000;
         rd_q <= 1'b0;
      end else begin
         bitcnt_q <= bitcnt_d;
         shreg_q <= shreg_d;
         rd_q <= rd_d;
      end
   end

   // latch and pending erase command
   always_comb begin
      seen_d = done_s2_q;
      write_enable_latch_d = write_enable_latch_q & ~done_pend;
      valid_d = 1'b0;
      kind_d = kind_q;
      sidx_d = sidx_q;
      if (bitcnt_d == spi_erase_pkg::OP_BITS &&
          op8 == spi_erase_pkg::OP_WRITE_ENABLE && !busy_s2_q) begin
         write_enable_latch_d = 1'b1;
      end
      if (!busy_s2_q && latch_eff) begin
         if (bitcnt_d == spi_erase_pkg::OP_BITS &&
             op8 == spi_erase_pkg::OP_FULL_ERASE) begin
            valid_d = 1'b1;
            kind_d = spi_erase_pkg::KIND_FULL;
         end
         if (bitcnt_d == spi_erase_pkg::ADDR_CMD_BITS &&
             (op32 == spi_erase_pkg::OP_SECTOR_ERASE ||
              op32 == spi_erase_pkg::OP_BLOCK_ERASE)) begin
            valid_d = 1'b1;
            kind_d = (op32 == spi_erase_pkg::OP_SECTOR_ERASE) ?
                     spi_erase_pkg::KIND_SECTOR :
                     spi_erase_pkg::KIND_BLOCK;
            sidx_d = shreg_d[spi_erase_pkg::SEC_ADDR_LSB +: SW];
         end
      end
   end

   always_ff @(posedge spi.sck or negedge arst_n_i) begin
      if (!arst_n_i) begin
         write_enable_latch_q <= 1'b0;
         seen_q <= 1'b0;
         valid_q <= 1'b0;
         kind_q <= spi_erase_pkg::KIND_SECTOR;
         sidx_q <= '0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
      end else begin
         write_enable_latch_q <= write_enable_latch_d;
         seen_q <= seen_d;
         valid_q <= valid_d;
         kind_q <= kind_d;
         sidx_q <= sidx_d;
         busy_s1_q <= busy_q;
         busy_s2_q <= busy_s1_q;
         done_s1_q <= done_tgl_q;
         done_s2_q <= done_s1_q;
      end
   end

   // status byte driven out on the falling edge
   always_comb begin
      sbit = 3'h7 - bitcnt_q[2:0];
      miso_d = rd_q ? status[sbit] : 1'b0;
      oe_d = rd_q;
   end

   always_ff @(negedge spi.sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         miso_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         miso_q <= miso_d;
         oe_q <= oe_d;
      end
   end

   assign spi.miso_out = miso_q;
   assign spi.miso_oe = oe_q;

   // ---------------- clk_i domain ----------------
   logic cs_s1_q, cs_s2_q, cs_prev_q;
   logic vld_s1_q, vld_s2_q;
   spi_erase_pkg::erase_kind_t kind_s1_q, kind_s2_q;
   logic [SW-1:0] sidx_s1_q, sidx_s2_q;
   logic cs_rise;

   spi_erase_pkg::dev_state_t state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic [NS-1:0] mask_q, mask_d;
   logic [NS-1:0] blank_q, blank_d;
   logic start_q, start_d;
   logic done_q, done_d;

   assign cs_rise = cs_s2_q & ~cs_prev_q;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      mask_d = mask_q;
      busy_d = busy_q;
      done_tgl_d = done_tgl_q;
      start_d = 1'b0;
      done_d = 1'b0;
      blank_d = blank_q & ~dirty_i;
      case (state_q)
         spi_erase_pkg::DEV_IDLE: begin
            if (cs_rise && vld_s2_q) begin
               mask_d = spi_erase_pkg::region_mask(kind_s2_q, sidx_s2_q);
               cnt_d = ERASE_CYCLES - 32'h0000_0001;
               busy_d = 1'b1;
               start_d = 1'b1;
               state_d = spi_erase_pkg::DEV_ERASE;
            end
         end
         spi_erase_pkg::DEV_ERASE: begin
            if (cnt_q == 32'h0000_0000) begin
               busy_d = 1'b0;
               done_d = 1'b1;
               done_tgl_d = ~done_tgl_q;
               blank_d = blank_d | mask_q;
               state_d = spi_erase_pkg::DEV_IDLE;
            end else begin
               cnt_d = cnt_q - 32'h0000_0001;
            end
         end
         default: begin
            state_d = spi_erase_pkg::DEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_prev_q <= 1'b1;
         vld_s1_q <= 1'b0;
         vld_s2_q <= 1'b0;
         kind_s1_q <= spi_erase_pkg::KIND_SECTOR;
         kind_s2_q <= spi_erase_pkg::KIND_SECTOR;
         sidx_s1_q <= '0;
         sidx_s2_q <= '0;
         state_q <= spi_erase_pkg::DEV_IDLE;
         cnt_q <= 32'h0000_0000;
         mask_q <= '0;
         blank_q <= '0;
         busy_q <= 1'b0;
         done_tgl_q <= 1'b0;
         start_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cs_s1_q <= spi.cs_n;
         cs_s2_q <= cs_s1_q;
         cs_prev_q <= cs_s2_q;
         vld_s1_q <= valid_q;
         vld_s2_q <= vld_s1_q;
         kind_s1_q <= kind_q;
         kind_s2_q <= kind_s1_q;
         sidx_s1_q <= sidx_q;
         sidx_s2_q <= sidx_s1_q;
         state_q <= state_d;
         cnt_q <= cnt_d;
         mask_q <= mask_d;
         blank_q <= blank_d;
         busy_q <= busy_d;
         done_tgl_q <= done_tgl_d;
         start_q <= start_d;
         done_q <= done_d;
      end
   end

   assign erase_start_o = start_q;
   assign erase_done_o = done_q;
   assign busy_o = busy_q;
   assign erase_mask_o = mask_q;
   assign blank_o = blank_q;
endmodule
`default_nettype wire

/* hw/spi_erase_host.sv */
// host end: frames erase, write enable and status commands on the link
`timescale 1ns/10ps
`default_nettype none
module spi_erase_host #(
   parameter int HALF_DIV = spi_erase_pkg::HOST_HALF_DIV,
   parameter int GAP = spi_erase_pkg::HOST_GAP
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   spi_erase_if.host spi,
   input wire logic req_valid_i,
   input wire spi_erase_pkg::host_cmd_t req_cmd_i,
   input wire logic [23:0] req_addr_i,
   output logic req_ready_o,
   output logic [7:0] status_o,
   output logic status_valid_o
);
   spi_erase_pkg::host_state_t state_q, state_d;
   logic [7:0] div_q, div_d;
   logic [5:0] bit_q, bit_d;
   logic [5:0] last_q, last_d;
   logic [31:0] tx_q, tx_d;
   logic [7:0] rx_q, rx_d;
   logic sck_q, sck_d;
   logic cs_n_q, cs_n_d;
   logic mosi_q, mosi_d;
   logic ready_q, ready_d;
   logic [7:0] status_q, status_d;
   logic stv_q, stv_d;
   logic is_rd_q, is_rd_d;
   logic miso_s1_q, miso_s2_q;

   always_comb begin
      state_d = state_q;
      div_d = div_q;
      bit_d = bit_q;
      last_d = last_q;
      tx_d = tx_q;
      rx_d = rx_q;
      sck_d = sck_q;
      cs_n_d = cs_n_q;
      mosi_d = mosi_q;
      ready_d = ready_q;
      status_d = status_q;
      stv_d = 1'b0;
      is_rd_d = is_rd_q;
      case (state_q)
         spi_erase_pkg::HOST_IDLE: begin
            ready_d = 1'b1;
            if (req_valid_i && ready_q) begin
               ready_d = 1'b0;
               cs_n_d = 1'b0;
               is_rd_d = req_cmd_i == spi_erase_pkg::CMD_READ_STATUS;
               case (req_cmd_i)
                  spi_erase_pkg::CMD_WRITE_ENABLE: begin
                     tx_d = {spi_erase_pkg::OP_WRITE_ENABLE, 24'h00_0000};
                     last_d = spi_erase_pkg::OP_BITS - 6'h01;
                  end
                  spi_erase_pkg::CMD_READ_STATUS: begin
                     tx_d = {spi_erase_pkg::OP_READ_STATUS, 24'h00_0000};
                     last_d = spi_erase_pkg::STATUS_BITS - 6'h01;
                  end
                  spi_erase_pkg::CMD_SECTOR_ERASE: begin
                     tx_d = {spi_erase_pkg::OP_SECTOR_ERASE, req_addr_i};
                     last_d = spi_erase_pkg::ADDR_CMD_BITS - 6'h01;
                  end
                  spi_erase_pkg::CMD_BLOCK_ERASE: begin
                     tx_d = {spi_erase_pkg::OP_BLOCK_ERASE, req_addr_i};
                     last_d = spi_erase_pkg::ADDR_CMD_BITS - 6'h01;
                  end
                  default: begin
                     tx_d = {spi_erase_pkg::OP_FULL_ERASE, 24'h00_0000};
                     last_d = spi_erase_pkg::OP_BITS - 6'h01;
                  end
               endcase
               mosi_d = tx_d[31];
               div_d = 8'h00;
               bit_d = 6'h00;
               state_d = spi_erase_pkg::HOST_SHIFT;
            end
         end
         spi_erase_pkg::HOST_SHIFT: begin
            if (div_q == 8'(HALF_DIV - 1)) begin
               div_d = 8'h00;
               if (!sck_q) begin
                  sck_d = 1'b1;
                  rx_d = {rx_q[6:0], miso_s2_q};
               end else begin
                  sck_d = 1'b0;
                  if (bit_q == last_q) begin
                     state_d = spi_erase_pkg::HOST_HOLD;
                  end else begin
                     bit_d = bit_q + 6'h01;
                     tx_d = {tx_q[30:0], 1'b0};
                     mosi_d = tx_q[30];
                  end
               end
            end else begin
               div_d = div_q + 8'h01;
            end
         end
         spi_erase_pkg::HOST_HOLD: begin
            if (div_q == 8'(HALF_DIV - 1)) begin
               div_d = 8'h00;
               cs_n_d = 1'b1;
               if (is_rd_q) begin
                  status_d = rx_q;
                  stv_d = 1'b1;
               end
               state_d = spi_erase_pkg::HOST_WAIT;
            end else begin
               div_d = div_q + 8'h01;
            end
         end
         spi_erase_pkg::HOST_WAIT: begin
            if (div_q == 8'(GAP - 1)) begin
               div_d = 8'h00;
               state_d = spi_erase_pkg::HOST_IDLE;
            end else begin
               div_d = div_q + 8'h01;
            end
         end
         default: begin
            state_d = spi_erase_pkg::HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= spi_erase_pkg::HOST_IDLE;
         div_q <= 8'h00;
         bit_q <= 6'h00;
         last_q <= 6'h00;
         tx_q <= 32'h0000_0000;
         rx_q <= 8'h00;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         mosi_q <= 1'b0;
         ready_q <= 1'b0;
         status_q <= 8'h00;
         stv_q <= 1'b0;
         is_rd_q <= 1'b0;
         miso_s1_q <= 1'b1;
         miso_s2_q <= 1'b1;
      end else begin
         state_q <= state_d;
         div_q <= div_d;
         bit_q <= bit_d;
         last_q <= last_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         sck_q <= sck_d;
         cs_n_q <= cs_n_d;
         mosi_q <= mosi_d;
         ready_q <= ready_d;
         status_q <= status_d;
         stv_q <= stv_d;
         is_rd_q <= is_rd_d;
         miso_s1_q <= spi.miso;
         miso_s2_q <= miso_s1_q;
      end
   end

   assign spi.sck = sck_q;
   assign spi.cs_n = cs_n_q;
   assign spi.mosi = mosi_q;
   assign req_ready_o = ready_q;
   assign status_o = status_q;
   assign status_valid_o = stv_q;
endmodule
`default_nettype wire

/* test/spi_erase_monitor.sv */
// assertions on the erase link and the device erase outputs
`timescale 1ns/10ps
`default_nettype none
module spi_erase_monitor #(
   parameter int unsigned ERASE_CYCLES = 600
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic miso_oe,
   input wire logic busy_o,
   input wire logic erase_start_o,
   input wire logic erase_done_o
);
   localparam int DONE_MIN = int'(ERASE_CYCLES) - 1;
   localparam int DONE_MAX = int'(ERASE_CYCLES) + 1;

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // link clock lead-in and high phase, host divider of four
   sequence s_frame_lead;
      !sck [*4] ##1 sck;
   endsequence
   sequence s_sck_high;
      sck [*4] ##1 !sck;
   endsequence

   property p_sck_idle;
      cs_n |-> !sck;
   endproperty
   property p_frame_lead;
      $fell(cs_n) |-> s_frame_lead;
   endproperty
   property p_sck_high;
      $rose(sck) |-> s_sck_high;
   endproperty
   property p_oe_frame;
      miso_oe |-> !cs_n;
   endproperty
   property p_start_busy;
      erase_start_o |-> busy_o ##1 busy_o;
   endproperty
   property p_start_cs;
      erase_start_o |-> cs_n && $past(cs_n, 2);
   endproperty
   property p_start_idle;
      erase_start_o |-> !$past(busy_o);
   endproperty
   property p_done_time;
      erase_start_o |-> ##[DONE_MIN:DONE_MAX] erase_done_o;
   endproperty
   property p_busy_end;
      $fell(busy_o) |-> erase_done_o;
   endproperty

   a_sck_idle: assert property (p_sck_idle)
      else $error("link clock moved while deselected");
   a_frame_lead: assert property (p_frame_lead)
      else $error("frame lead-in length wrong");
   a_sck_high: assert property (p_sck_high)
      else $error("link clock high phase wrong");
   a_oe_frame: assert property (p_oe_frame)
      else $error("device drove data while deselected");
   a_start_busy: assert property (p_start_busy)
      else $error("busy not raised at erase start");
   a_start_cs: assert property (p_start_cs)
      else $error("erase started without select rise");
   a_start_idle: assert property (p_start_idle)
      else $error("erase started while busy");
   a_done_time: assert property (p_done_time)
      else $error("erase length wrong");
   a_busy_end: assert property (p_busy_end)
      else $error("busy dropped without done");

   c_start: cover property (erase_start_o);
endmodule
`default_nettype wire

/* test/spi_erase_commands_tb.sv */
// testbench: host and device facing each other, plus a rule-breaking link
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
   end \
end
module spi_flash_erase_commands_tb;
   localparam int unsigned EC = 600;
   logic clk_i, arst_n_i, req_valid_i, req_ready_o, status_valid_o;
   spi_erase_pkg::host_cmd_t req_cmd_i, c;
   logic [23:0] req_addr_i, a;
   logic [7:0] status_o, dirty_i, mask_a, blank_a, mask_b, blank_b, s, d;
   logic [7:0] exp_blank;
   logic start_a, done_a, busy_a, start_b, done_b, busy_b;
   int bad_count, checks_done, starts_a, starts_b, n0, dones_a, dones_b;
   spi_erase_pkg::host_cmd_t kinds [3] = '{spi_erase_pkg::CMD_SECTOR_ERASE,
      spi_erase_pkg::CMD_BLOCK_ERASE, spi_erase_pkg::CMD_FULL_ERASE};

   spi_erase_if link();
   spi_erase_if link_b();

   spi_erase_host #(.HALF_DIV(4), .GAP(8)) i_spi_erase_host (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .spi(link),
      .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
      .req_addr_i(req_addr_i), .req_ready_o(req_ready_o),
      .status_o(status_o), .status_valid_o(status_valid_o));
   spi_erase_dev #(.ERASE_CYCLES(EC)) i_spi_erase_dev (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .spi(link), .dirty_i(dirty_i),
      .erase_start_o(start_a), .erase_done_o(done_a), .busy_o(busy_a),
      .erase_mask_o(mask_a), .blank_o(blank_a));
   spi_erase_dev #(.ERASE_CYCLES(EC)) i_spi_erase_dev_b (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .spi(link_b), .dirty_i(8'h00),
      .erase_start_o(start_b), .erase_done_o(done_b), .busy_o(busy_b),
      .erase_mask_o(mask_b), .blank_o(blank_b));
   spi_erase_monitor #(.ERASE_CYCLES(EC)) i_spi_erase_monitor (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .sck(link.sck),
      .cs_n(link.cs_n), .miso_oe(link.miso_oe), .busy_o(busy_a),
      .erase_start_o(start_a), .erase_done_o(done_a));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (start_a === 1'b1) starts_a++;
      if (start_b === 1'b1) starts_b++;
      if (done_a === 1'b1) dones_a++;
      if (done_b === 1'b1) dones_b++;
   end

   function automatic logic [7:0] want_mask(spi_erase_pkg::host_cmd_t k,
                                            logic [23:0] ad);
      if (k == spi_erase_pkg::CMD_SECTOR_ERASE) return 8'h01 << ad[14:12];
      return 8'hff;
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic host_req(spi_erase_pkg::host_cmd_t k, logic [23:0] ad);
      int n;
      n = 0;
      req_valid_i <= 1'b1;
      req_cmd_i <= k;
      req_addr_i <= ad;
      @(posedge clk_i);
      while (req_ready_o !== 1'b1 && n < 2000) begin
         n++;
         @(posedge clk_i);
      end
      req_valid_i <= 1'b0;
      if (n == 2000) bad_count++;
      @(posedge clk_i);
   endtask

   task automatic rd_status(output logic [7:0] st);
      int n;
      n = 0;
      host_req(spi_erase_pkg::CMD_READ_STATUS, 24'h000000);
      while (status_valid_o !== 1'b1 && n < 400) begin
         n++;
         @(posedge clk_i);
      end
      st = status_o;
      if (n == 400) bad_count++;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      rd_status(s);
      while (s[spi_erase_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20) begin
         n++;
         rd_status(s);
      end
      `CHK("status after erase", 8'h00, s)
   endtask

   // bench-made link clock, 32 ns, only inside frames
   task automatic b_bit(logic v);
      link_b.mosi = v;
      #16 link_b.sck = 1'b1;
      #16 link_b.sck = 1'b0;
   endtask

   task automatic b_send(logic [7:0] op, int extra);
      link_b.cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) b_bit(op[i]);
      for (int i = 0; i < extra; i++) b_bit(1'($urandom()));
      #16 link_b.cs_n = 1'b1;
      link_b.mosi = ~link_b.mosi;
      #400;
   endtask

   initial begin
      repeat (60000) @(posedge clk_i);
      bad_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(6));
      arst_n_i = 1'b0;
      req_valid_i = 1'b0;
      req_cmd_i = spi_erase_pkg::CMD_READ_STATUS;
      req_addr_i = 24'h000000;
      dirty_i = 8'h00;
      link_b.sck = 1'b0;
      link_b.cs_n = 1'b1;
      link_b.mosi = 1'b0;
      exp_blank = 8'h00;
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      // broken and clean frames on the second link
      b_send(spi_erase_pkg::OP_FULL_ERASE, 0);
      `CHK("start without latch", 0, starts_b)
      b_send(spi_erase_pkg::OP_WRITE_ENABLE, 0);
      b_send(spi_erase_pkg::OP_SECTOR_ERASE, 25);
      `CHK("start after extra bit", 0, starts_b)
      b_send(spi_erase_pkg::OP_FULL_ERASE, 8);
      `CHK("start with address", 0, starts_b)
      b_send(spi_erase_pkg::OP_FULL_ERASE, 0);
      `CHK("start on clean frame", 1, starts_b)
      @(posedge clk_i);
      n0 = 0;
      while (busy_b !== 1'b0 && n0 < 2000) begin
         n0++;
         @(posedge clk_i);
      end
      `CHK("full erase region", 8'hff, mask_b)
      `CHK("full erase blank", 8'hff, blank_b)
      $display("test second link done");
      // main link: idle status and erase without latch
      rd_status(s);
      `CHK("status after reset", 8'h00, s)
      `CHK("done on second link", 1, dones_b)
      host_req(spi_erase_pkg::CMD_SECTOR_ERASE, 24'($urandom()));
      repeat (20) @(posedge clk_i);
      rd_status(s);
      `CHK("status no latch", 8'h00, s)
      `CHK("start no latch", 0, starts_a)
      `CHK("mask no latch", 8'h00, mask_a)
      $display("test no latch done");
      for (int k = 0; k < 5; k++) begin
         c = (k < 3) ? kinds[k] : spi_erase_pkg::CMD_SECTOR_ERASE;
         a = (k == 0) ? 24'hff7fff : 24'($urandom());
         d = 8'($urandom());
         dirty_i <= d;
         repeat (4) @(posedge clk_i);
         dirty_i <= 8'h00;
         repeat (3) @(posedge clk_i);
         exp_blank = exp_blank & ~d;
         `CHK("blank after dirty", exp_blank, blank_a)
         host_req(spi_erase_pkg::CMD_WRITE_ENABLE, 24'h000000);
         rd_status(s);
         `CHK("latch set", 8'h02, s)
         n0 = starts_a;
         host_req(c, a);
         host_req(c, a ^ 24'h001000);
         rd_status(s);
         `CHK("status while erasing", 8'h03, s)
         wait_idle();
         `CHK("erase starts", n0 + 1, starts_a)
         `CHK("erase finishes", n0 + 1, dones_a)
         exp_blank = exp_blank | want_mask(c, a);
         `CHK("erase region", want_mask(c, a), mask_a)
         `CHK("blank after erase", exp_blank, blank_a)
         $display("test erase kind %0d done", k);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
